/* hdl/rcs_pkg.sv */
// constants and types for the reset and clock select block
package rcs_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int          RCS_AW          = 4;
  localparam int          RCS_DW          = 16;
  localparam logic [3:0]  RCS_ADDR_EN     = 4'h0;
  localparam logic [3:0]  RCS_ADDR_SWRST  = 4'h1;
  localparam logic [3:0]  RCS_ADDR_CAUSE  = 4'h2;
  localparam logic [3:0]  RCS_ADDR_SYSCLK = 4'h3;
  localparam logic [3:0]  RCS_ADDR_USBCLK = 4'h4;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int          RCS_EN_VDD      = 0;
  localparam int          RCS_EN_USB      = 1;
  localparam int          RCS_EN_WDT      = 2;
  localparam int          RCS_EN_MCLK     = 3;
  localparam int          RCS_EN_CMP      = 4;
  localparam int          RCS_EN_SW       = 5;
  localparam int          RCS_EN_LOCK     = 7;
  localparam int          RCS_SWRST_GO    = 0;
  localparam int          RCS_USB_DIRECT  = 0;
  localparam int          RCS_USB_MEXT    = 1;

  // ------------------------------------------------------------
  // reset values and counts
  // ------------------------------------------------------------
  localparam logic [5:0]  RCS_EN_RST      = 6'h05;
  localparam logic [4:0]  RCS_HOLD_CYC    = 5'h10;
  localparam int          RCS_NSYNC       = 13;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    RCS_CLK_HFOSC,
    RCS_CLK_LFOSC,
    RCS_CLK_EXTOSC,
    RCS_CLK_MULT_DIV2
  } rcs_sysclk_e;

  typedef enum logic [1:0] {
    RCS_ST_RUN,
    RCS_ST_RESET,
    RCS_ST_HOLD
  } rcs_state_e;

  typedef struct packed {
    logic flash;
    logic pin;
    logic sw;
    logic cmp;
    logic mclk;
    logic wdt;
    logic usb;
    logic vdd;
    logic por;
  } rcs_src_s;

endpackage

/* hdl/rcs_sync.sv */
// two-flop synchroniser bank for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none

module rcs_sync
#(
  parameter int W = 1
)
(
  // clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_rst_n,
  // data
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  // ------------------------------------------------------------
  // one pair of flops per bit
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++)
    begin : g_bit
      always_ff @(posedge i_core_clk)
      begin
        if (!i_rst_n)
        begin
          meta_reg[gi] <= 1'b0;
          q_reg[gi]    <= 1'b0;
        end
        else
        begin
          meta_reg[gi] <= i_d[gi];
          q_reg[gi]    <= meta_reg[gi];
        end
      end
    end
  endgenerate

  assign o_q = q_reg;

endmodule

`default_nettype wire

/* hdl/rcs_top.sv */
// reset source merger and system / usb clock selection
//
// Overview of operation
// - Any of nine requests (por, supply, usb, wdt, clock, comparator, sw, pin, flash) resets.
// - Every source but power-on, the reset pin and flash violation has a software disable bit.
// - After power-on, software may lock the watchdog reset on so writes cannot clear it.
// - An enabled supply monitor holds reset while supply is below the reset threshold voltage.
// - A usb bus reset or any vbus level change raises the usb reset request.
// - The system clock runs from fast or slow internal, external or halved multiplier output.
// - The system clock source can be changed at run time with no reset.
// - Full-speed usb clock is the internal oscillator with clock recovery, multiplied by four.
// - Low-speed usb clock may come straight from the internal oscillator.
// - The external oscillator may feed the multiplier instead.
// - System clock selection and usb clock selection never disturb each other.
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module rcs_top
  import rcs_pkg::*;
(
  // clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_n,
  // register port
  input  wire logic [RCS_AW-1:0] i_addr,
  input  wire logic [RCS_DW-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [RCS_DW-1:0] o_rdata,
  // reset sources, asynchronous
  input  wire logic              i_por,
  input  wire logic              i_vdd_below,
  input  wire logic              i_usb_bus_rst,
  input  wire logic              i_vbus,
  input  wire logic              i_wdt_expire,
  input  wire logic              i_mclk_missing,
  input  wire logic              i_cmp_level,
  input  wire logic              i_rst_pin_n,
  input  wire logic              i_flash_err,
  // oscillator ready, indexed by rcs_sysclk_e
  input  wire logic [3:0]        i_osc_ready,
  // results
  output logic                   o_sys_rst,
  output rcs_sysclk_e            o_sysclk_sel,
  output logic                   o_usbclk_direct,
  output logic                   o_mult_ext,
  output logic                   o_clk_rec_en
);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [RCS_NSYNC-1:0] raw;
  logic [RCS_NSYNC-1:0] syn;
  logic                 por_s;
  logic                 vdd_s;
  logic                 usbrst_s;
  logic                 vbus_s;
  logic                 wdt_s;
  logic                 mclk_s;
  logic                 cmp_s;
  logic                 pin_s;
  logic                 flash_s;
  logic [3:0]           rdy_s;

  // pin inverted ahead of the first flop so every bit is active high
  assign raw = {i_osc_ready, i_flash_err, ~i_rst_pin_n, i_cmp_level,
                i_mclk_missing, i_wdt_expire, i_vbus, i_usb_bus_rst,
                i_vdd_below, i_por};

  rcs_sync #(.W(RCS_NSYNC)) u_sync
  (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_d        (raw),
    .o_q        (syn)
  );

  assign {rdy_s, flash_s, pin_s, cmp_s, mclk_s, wdt_s, vbus_s, usbrst_s,
          vdd_s, por_s} = syn;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  rcs_state_e  state_reg;
  rcs_state_e  state_next;
  logic [4:0]  hold_reg;
  logic        rst_reg;
  rcs_src_s    cause_reg;
  logic [5:0]  en_reg;
  logic        lock_reg;
  logic        sw_req_reg;
  logic        vbus_d_reg;
  rcs_sysclk_e clk_req_reg;
  rcs_sysclk_e sys_sel_reg;
  logic        usb_direct_reg;
  logic        mult_ext_reg;
  logic        rec_reg;
  logic [RCS_DW-1:0] rdata_reg;

  rcs_src_s    req;
  logic        any_req;
  logic        wdt_on;
  logic        vbus_chg;
  logic        wr_ok;

  assign wdt_on   = en_reg[RCS_EN_WDT] | lock_reg;
  assign vbus_chg = vbus_s ^ vbus_d_reg;
  // writes during system reset are dropped, the registers are re-initialising
  assign wr_ok    = i_wr & ~rst_reg;

  // ------------------------------------------------------------
  // request merge
  // ------------------------------------------------------------
  always_comb
  begin
    req.por   = por_s;
    req.vdd   = vdd_s & en_reg[RCS_EN_VDD];
    req.usb   = (usbrst_s | vbus_chg) & en_reg[RCS_EN_USB];
    req.wdt   = wdt_s & wdt_on;
    req.mclk  = mclk_s & en_reg[RCS_EN_MCLK];
    req.cmp   = cmp_s & en_reg[RCS_EN_CMP];
    req.sw    = sw_req_reg & en_reg[RCS_EN_SW];
    req.pin   = pin_s;
    req.flash = flash_s;
  end

  assign any_req = |req;

  // ------------------------------------------------------------
  // reset sequencer
  // ------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      RCS_ST_RUN:
        if (any_req)
          state_next = RCS_ST_RESET;
      RCS_ST_RESET:
        if (!any_req)
          state_next = RCS_ST_HOLD;
      RCS_ST_HOLD:
        if (any_req)
          state_next = RCS_ST_RESET;
        else if (hold_reg == RCS_HOLD_CYC - 5'h01)
          state_next = RCS_ST_RUN;
      default:
        state_next = RCS_ST_RESET;
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      state_reg <= RCS_ST_RESET;
      rst_reg   <= 1'b1;
      hold_reg  <= '0;
    end
    else
    begin
      state_reg <= state_next;
      rst_reg   <= (state_next != RCS_ST_RUN);
      // stretch so every released request gives a clean minimum pulse
      if (state_reg == RCS_ST_HOLD && state_next == RCS_ST_HOLD)
        hold_reg <= hold_reg + 5'h01;
      else
        hold_reg <= '0;
    end
  end

  // new event replaces old flags, later requests in the same event add on
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      cause_reg <= '0;
    else if (state_reg == RCS_ST_RUN && any_req)
      cause_reg <= req;
    else if (state_reg != RCS_ST_RUN)
      cause_reg <= cause_reg | req;
  end

  // ------------------------------------------------------------
  // source enables and watchdog lock
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n || rst_reg)
      en_reg <= RCS_EN_RST;
    else if (wr_ok && i_addr == RCS_ADDR_EN)
      en_reg <= i_wdata[5:0];
  end

  // lock only while the standing cause is power-on; only power-on undoes it
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n || req.por)
      lock_reg <= 1'b0;
    else if (wr_ok && i_addr == RCS_ADDR_EN && i_wdata[RCS_EN_LOCK]
             && cause_reg.por)
      lock_reg <= 1'b1;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      sw_req_reg <= 1'b0;
    else
      sw_req_reg <= wr_ok && i_addr == RCS_ADDR_SWRST
                    && i_wdata[RCS_SWRST_GO];
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      vbus_d_reg <= 1'b0;
    else
      vbus_d_reg <= vbus_s;
  end

  // ------------------------------------------------------------
  // system clock select
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n || rst_reg)
      clk_req_reg <= RCS_CLK_HFOSC;
    else if (wr_ok && i_addr == RCS_ADDR_SYSCLK)
      clk_req_reg <= rcs_sysclk_e'(i_wdata[1:0]);
  end

  // switch only once the target runs, so a dead source never stalls the core
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n || rst_reg)
      sys_sel_reg <= RCS_CLK_HFOSC;
    else if (clk_req_reg != sys_sel_reg && rdy_s[clk_req_reg])
      sys_sel_reg <= clk_req_reg;
  end

  // ------------------------------------------------------------
  // usb clock select
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n || rst_reg)
    begin
      usb_direct_reg <= 1'b0;
      mult_ext_reg   <= 1'b0;
    end
    else if (wr_ok && i_addr == RCS_ADDR_USBCLK)
    begin
      usb_direct_reg <= i_wdata[RCS_USB_DIRECT];
      mult_ext_reg   <= i_wdata[RCS_USB_MEXT];
    end
  end

  // recovery whenever the internal oscillator is the usb reference
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      rec_reg <= 1'b1;
    else
      rec_reg <= usb_direct_reg | ~mult_ext_reg;
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n || !i_rd)
      rdata_reg <= '0;
    else
      case (i_addr)
        RCS_ADDR_EN:
          rdata_reg <= {8'h00, lock_reg, 1'b0, en_reg[5:3], wdt_on,
                        en_reg[1:0]};
        RCS_ADDR_CAUSE:
          rdata_reg <= {7'h0, cause_reg};
        RCS_ADDR_SYSCLK:
          rdata_reg <= {12'h000, sys_sel_reg, clk_req_reg};
        RCS_ADDR_USBCLK:
          rdata_reg <= {13'h0, rec_reg, mult_ext_reg, usb_direct_reg};
        default:
          rdata_reg <= '0;
      endcase
  end

  assign o_rdata         = rdata_reg;
  assign o_sys_rst       = rst_reg;
  assign o_sysclk_sel    = sys_sel_reg;
  assign o_usbclk_direct = usb_direct_reg;
  assign o_mult_ext      = mult_ext_reg;
  assign o_clk_rec_en    = rec_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  AST_MUST_RESET: assert property ((por_s || pin_s || flash_s) |=> o_sys_rst)
    else $error("undisableable source did not reset");
  AST_VDD_RESET: assert property ((vdd_s && en_reg[RCS_EN_VDD]) |=> o_sys_rst)
    else $error("supply monitor reset missing");
  AST_USB_RESET: assert property ((vbus_chg && en_reg[RCS_EN_USB]) |=> o_sys_rst)
    else $error("vbus change did not reset");
  AST_WDT_LOCK: assert property ((lock_reg && !por_s) |=> lock_reg)
    else $error("watchdog lock lost");
  AST_WDT_LOCKED_RST: assert property ((lock_reg && wdt_s) |=> o_sys_rst)
    else $error("locked watchdog did not reset");
  AST_RST_STRETCH: assert property ($rose(o_sys_rst) |-> o_sys_rst[*8])
    else $error("reset pulse too short");
  AST_CAUSE_LOAD: assert property ($rose(o_sys_rst) |-> cause_reg == $past(req))
    else $error("cause flags not loaded");
  AST_CAUSE_KEEP: assert property ((!rst_reg && !any_req) |=> $stable(cause_reg))
    else $error("cause flags changed without reset");
  AST_CLK_SWITCH: assert property ((clk_req_reg != sys_sel_reg && rdy_s[clk_req_reg]
                                    && !rst_reg) |=> sys_sel_reg == $past(clk_req_reg))
    else $error("clock switch not taken");
  AST_USB_INDEP: assert property ((wr_ok && i_addr == RCS_ADDR_USBCLK)
                                  |=> $stable(clk_req_reg))
    else $error("usb write moved system clock");
  AST_REC_FS: assert property ((!usb_direct_reg && !mult_ext_reg) |=> o_clk_rec_en)
    else $error("recovery off for internal usb clock");

  COV_SW_RST: cover property (req.sw ##1 o_sys_rst);
  COV_LOCK: cover property ($rose(lock_reg));
  COV_CLK_SW: cover property ($changed(sys_sel_reg) && !rst_reg);
  COV_USB_DIRECT: cover property ($rose(usb_direct_reg));

endmodule

`default_nettype wire

/* verification/tb_top.sv */
// self-checking bench for the reset and clock select block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import rcs_pkg::*;

  // ------------------------------------------------------------
  // design hookup
  // ------------------------------------------------------------
  logic              i_core_clk = 1'b0;
  logic              i_rst_n    = 1'b0;
  logic [RCS_AW-1:0] i_addr     = '0;
  logic [RCS_DW-1:0] i_wdata    = '0;
  logic              i_wr       = 1'b0;
  logic              i_rd       = 1'b0;
  logic [RCS_DW-1:0] o_rdata;
  logic              i_por = 1'b1, i_vdd_below = 1'b0, i_usb_bus_rst = 1'b0, i_vbus = 1'b0;
  logic              i_wdt_expire = 1'b0, i_mclk_missing = 1'b0, i_cmp_level = 1'b0;
  logic              i_rst_pin_n = 1'b1, i_flash_err = 1'b0;
  logic [3:0]        i_osc_ready = 4'h1;
  logic              o_sys_rst, o_usbclk_direct, o_mult_ext, o_clk_rec_en;
  rcs_sysclk_e       o_sysclk_sel;
  int                n_fail = 0;
  int                n_tests = 0;
  int                cyc = 0;

  always #10 i_core_clk = ~i_core_clk;

  rcs_top u_rcs_top (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_por(i_por), .i_vdd_below(i_vdd_below),
    .i_usb_bus_rst(i_usb_bus_rst), .i_vbus(i_vbus), .i_wdt_expire(i_wdt_expire),
    .i_mclk_missing(i_mclk_missing), .i_cmp_level(i_cmp_level), .i_rst_pin_n(i_rst_pin_n),
    .i_flash_err(i_flash_err), .i_osc_ready(i_osc_ready), .o_sys_rst(o_sys_rst),
    .o_sysclk_sel(o_sysclk_sel), .o_usbclk_direct(o_usbclk_direct),
    .o_mult_ext(o_mult_ext), .o_clk_rec_en(o_clk_rec_en)
  );

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic end_of_test();
    if (n_fail == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ceiling well above the roughly 700 cycles the sequence needs
  always @(posedge i_core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc > 20000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    // step off the edge so outputs launched there have settled
    #1;
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input string name, input logic [3:0] a, input logic [15:0] exp);
    @(posedge i_core_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd   <= 1'b0;
    #1;
    chk(name, exp, o_rdata);
  endtask

  // poll just after each edge, never in the edge's own time step
  task automatic wait_rst(input logic lvl, input int max);
    #1;
    for (int i = 0; i < max && o_sys_rst !== lvl; i++)
    begin
      @(posedge i_core_clk);
      #1;
    end
    chk("sys_rst", {15'h0, lvl}, {15'h0, o_sys_rst});
  endtask

  // drive one source by its cause-bit index, or the usb bus reset by index 9
  task automatic trig(input int k, input logic on);
    @(posedge i_core_clk);
    case (k)
      0: i_por          <= on;
      1: i_vdd_below    <= on;
      2: if (on) i_vbus <= ~i_vbus;
      3: i_wdt_expire   <= on;
      4: i_mclk_missing <= on;
      5: i_cmp_level    <= on;
      7: i_rst_pin_n    <= ~on;
      8: i_flash_err    <= on;
      9: i_usb_bus_rst  <= on;
      default: ;
    endcase
    if (k == 6 && on)
      wr(RCS_ADDR_SWRST, 16'h0001);
  endtask

  task automatic usb_chk(input logic dir, input logic ext, input logic rec);
    repeat (3) @(posedge i_core_clk);
    #1;
    chk("usb_outs", {13'h0, dir, ext, rec}, {13'h0, o_usbclk_direct, o_mult_ext, o_clk_rec_en});
    chk("sysclk_kept", 16'h0003, {14'h0, o_sysclk_sel});
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    i_por <= 1'b0;
    wait_rst(1'b0, 60);
    rd_chk("cause", RCS_ADDR_CAUSE, 16'h0001);
    rd_chk("en_reset", RCS_ADDR_EN, 16'h0005);
    wr(RCS_ADDR_EN, 16'h0080);
    rd_chk("en_locked", RCS_ADDR_EN, 16'h0084);
    // every source except power-on, enabled, held long
    for (int k = 1; k < 9; k++)
    begin
      wr(RCS_ADDR_EN, 16'h003f);
      trig(k, 1'b1);
      wait_rst(1'b1, 8);
      repeat (30) @(posedge i_core_clk);
      // enables fall back to their reset value, so only these keep reset asserted
      chk("held", {15'h0, k == 1 || k == 3 || k >= 7}, {15'h0, o_sys_rst});
      trig(k, 1'b0);
      wait_rst(1'b0, 40);
      rd_chk("cause", RCS_ADDR_CAUSE, 16'h0001 << k);
      rd_chk("en_after", RCS_ADDR_EN, 16'h0085);
    end
    // disabled sources must not reset
    wr(RCS_ADDR_EN, 16'h0000);
    for (int k = 1; k < 7; k++)
    begin
      if (k == 3)
        continue;
      trig(k, 1'b1);
      repeat (12) @(posedge i_core_clk);
      chk("no_rst", 16'h0000, {15'h0, o_sys_rst});
      trig(k, 1'b0);
    end
    // let the disabled vbus edge pass before enabling usb
    trig(2, 1'b1);
    repeat (4) @(posedge i_core_clk);
    chk("no_rst", 16'h0000, {15'h0, o_sys_rst});
    wr(RCS_ADDR_EN, 16'h0002);
    trig(2, 1'b1);
    wait_rst(1'b1, 8);
    wait_rst(1'b0, 40);
    rd_chk("cause_vbus", RCS_ADDR_CAUSE, 16'h0004);
    wr(RCS_ADDR_EN, 16'h0002);
    trig(9, 1'b1);
    wait_rst(1'b1, 8);
    trig(9, 1'b0);
    wait_rst(1'b0, 40);
    rd_chk("cause_busrst", RCS_ADDR_CAUSE, 16'h0004);
    // watchdog locked on despite its enable being cleared
    wr(RCS_ADDR_EN, 16'h0000);
    trig(3, 1'b1);
    wait_rst(1'b1, 8);
    trig(3, 1'b0);
    wait_rst(1'b0, 40);
    rd_chk("cause_wdt", RCS_ADDR_CAUSE, 16'h0008);
    // clock switch waits for ready
    wr(RCS_ADDR_SYSCLK, 16'h0002);
    repeat (6) @(posedge i_core_clk);
    chk("sel_wait", 16'h0000, {14'h0, o_sysclk_sel});
    rd_chk("sysclk_reg", RCS_ADDR_SYSCLK, 16'h0002);
    @(posedge i_core_clk);
    i_osc_ready <= 4'hf;
    repeat (6) @(posedge i_core_clk);
    chk("sel_ready", 16'h0002, {14'h0, o_sysclk_sel});
    for (int c = 0; c < 4; c++)
    begin
      wr(RCS_ADDR_SYSCLK, c[15:0]);
      repeat (6) @(posedge i_core_clk);
      chk("sel", c[15:0], {14'h0, o_sysclk_sel});
      chk("no_rst", 16'h0000, {15'h0, o_sys_rst});
    end
    wr(RCS_ADDR_USBCLK, 16'h0001);
    usb_chk(1'b1, 1'b0, 1'b1);
    wr(RCS_ADDR_USBCLK, 16'h0002);
    usb_chk(1'b0, 1'b1, 1'b0);
    rd_chk("usbclk_reg", RCS_ADDR_USBCLK, 16'h0002);
    wr(RCS_ADDR_USBCLK, 16'h0000);
    usb_chk(1'b0, 1'b0, 1'b1);
    wr(RCS_ADDR_SYSCLK, 16'h0001);
    repeat (6) @(posedge i_core_clk);
    chk("usb_kept", 16'h0001, {15'h0, o_clk_rec_en});
    rd_chk("unmapped", 4'hf, 16'h0000);
    // power-on clears lock; writes during reset dropped
    trig(0, 1'b1);
    wait_rst(1'b1, 8);
    wr(RCS_ADDR_SYSCLK, 16'h0002);
    trig(0, 1'b0);
    wait_rst(1'b0, 40);
    rd_chk("cause_por", RCS_ADDR_CAUSE, 16'h0001);
    rd_chk("en_unlock", RCS_ADDR_EN, 16'h0005);
    rd_chk("sysclk_drop", RCS_ADDR_SYSCLK, 16'h0000);
    end_of_test();
  end

endmodule

`default_nettype wire
